/* plc_arith_map.svh */
// Register offsets, field positions, limits and step counts of the integer arithmetic unit.
`ifndef PLC_ARITH_MAP_SVH
`define PLC_ARITH_MAP_SVH

`define REG_CTRL 8'h00
`define REG_SRC1 8'h01
`define REG_SRC2 8'h02
`define REG_DST 8'h03
`define REG_COUNT 8'h04
`define REG_FLAGS 8'h05
`define REG_STATUS 8'h06
`define DATA_BASE 8'h40

`define CTRL_OP_LSB 0
`define CTRL_FORM_BIT 3
`define CTRL_WIDE_BIT 4

`define FLAG_ZERO_BIT 0
`define FLAG_BORROW_BIT 1
`define FLAG_CARRY_BIT 2

`define STATUS_BUSY_BIT 0
`define STATUS_DIVZ_BIT 1
`define STATUS_STEPS_LSB 8

`define STATE_RST 0

`define S16_MAX 33'sh0_0000_7fff
`define S16_MIN 33'sh1_ffff_8000
`define S32_MAX 33'sh0_7fff_ffff
`define S32_MIN 33'sh1_8000_0000

`define STEPS_ADD 8'h07
`define STEPS_SUB 8'h07
`define STEPS_WIDE 8'h0d
`define STEPS_MUL 8'h07
`define STEPS_DIV 8'h07
`define STEPS_STEP 8'h03
`define STEPS_ROT 8'h05

`define FETCH_LAST 3'h6

`endif

/* plc_arith_pkg.sv */
// Types shared by the integer arithmetic unit.
package plc_arith_pkg;

  typedef enum logic [2:0] {
    SUM_OP = 3'b000,
    DIFFERENCE_OP = 3'b001,
    PRODUCT_OP = 3'b010,
    QUOTIENT_OP = 3'b011,
    PLUS_ONE_OP = 3'b100,
    MINUS_ONE_OP = 3'b101,
    SPIN_RIGHT_OP = 3'b110,
    SPIN_LEFT_OP = 3'b111
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10,
    ST_WRITE_HI = 2'b11
  } state_t;

endpackage

/* plc_arith_unit_chk.sv */
// Bound checker for scan timing, flag causes and flag readback of the arithmetic unit.
`timescale 1ns/1ps
`include "plc_arith_map.svh"
module plc_arith_unit_chk #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Scan and status
  input wire logic scan_strobe,
  input wire logic run_contact,
  input wire logic busy,
  input wire logic scan_done,
  input wire logic zero_flag,
  input wire logic borrow_flag,
  input wire logic carry_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_scan_answer: assert property (scan_strobe && !busy |=> busy ^ scan_done)
    else $error("accepted scan got no answer");
  a_busy_run: assert property ($rose(busy) |-> busy [*8])
    else $error("operation ended before fetch and execute");
  a_done_bound: assert property ($rose(busy) |-> ##[8:9] scan_done)
    else $error("operation did not finish in time");
  a_done_single: assert property (scan_done |-> !busy ##1 !scan_done)
    else $error("scan done not a single idle pulse");
  a_zero_cause: assert property ($rose(zero_flag) |-> $past(busy))
    else $error("zero flag rose without an operation");
  a_borrow_cause: assert property ($rose(borrow_flag) |-> $past(busy))
    else $error("borrow flag rose without an operation");
  a_carry_cause: assert property ($rose(carry_flag) |-> $past(busy))
    else $error("carry flag rose without an operation");
  a_flags_hold: assert property (!busy && !reg_wr |=>
    $stable({zero_flag, borrow_flag, carry_flag}))
    else $error("flags changed while idle");
  a_flag_readback: assert property (reg_rd && reg_addr == `REG_FLAGS |=>
    reg_rdata == {13'h0000, $past(carry_flag), $past(borrow_flag), $past(zero_flag)})
    else $error("flag readback differs from flag pins");

  c_fire: cover property ($rose(busy));
  c_idle_scan: cover property (scan_strobe && !busy ##1 scan_done);
  c_carry: cover property ($rose(carry_flag));
endmodule // plc_arith_unit_chk

bind plc_integer_arithmetic_unit plc_arith_unit_chk #(.DEPTH(DEPTH), .AW(AW)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scan_strobe(scan_strobe),
  .run_contact(run_contact), .busy(busy), .scan_done(scan_done), .zero_flag(zero_flag),
  .borrow_flag(borrow_flag), .carry_flag(carry_flag));

/* plc_integer_arithmetic_unit.sv */
// Integer arithmetic and rotate engine working on a bank of data registers once per scan.
`timescale 1ns/1ps
`include "plc_arith_map.svh"

// Operation
// RQ1: With enable on, add two signed source words and store the sum.
// RQ2: Subtract second source from first as signed values and store the difference.
// RQ3: Most significant bit is the sign; two's-complement arithmetic throughout.
// RQ4: Add or subtract with a zero result sets the zero flag.
// RQ5: Add or subtract below the signed minimum sets the borrow flag.
// RQ6: Add or subtract above the signed maximum sets the carry flag.
// RQ7: Subtract takes seven program steps, its wide form thirteen.
// RQ8: Multiply gives a 32-bit signed product, low word first, high word next.
// RQ9: Product sign bit follows signed operand rules, top bit gives the sign.
// RQ10: Divide stores signed quotient in first word, remainder in the next.
// RQ11: Continuous increment adds one on every scan with enable on.
// RQ12: Pulse increment adds one only on the scan where enable rises.
// RQ13: Increment wraps from the maximum to the minimum without saturating.
// RQ14: Decrement subtracts one each enabled scan, or once per rise in pulse form.
// RQ15: Decrement wraps from the minimum to the maximum without saturating.
// RQ16: Rotate right circularly shifts the destination word by the count.
// RQ17: The last bit rotated across the word boundary goes to the carry flag.
// RQ18: Rotate left circularly shifts the destination left by the count, pulse-driven.
// RQ19: With enable off, destinations and flags stay unchanged.
// RQ20: A zero divisor skips the divide and leaves both destination words alone.
module plc_integer_arithmetic_unit
  import plc_arith_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Scan and enable contact
  input wire logic scan_strobe,
  input wire logic run_contact,
  // Status
  output logic busy,
  output logic scan_done,
  output logic zero_flag,
  output logic borrow_flag,
  output logic carry_flag
);

  typedef struct packed {
    state_t st;
    logic [2:0] cnt;
    logic [5:0][15:0] opnd;
    logic [15:0] res_hi;
    logic run_meta;
    logic run_sync;
    logic run_prev;
    logic zero_flag;
    logic borrow_flag;
    logic carry_flag;
    logic div_zero;
    op_t op;
    logic pulse_form;
    logic wide;
    logic [AW-1:0] src1;
    logic [AW-1:0] src2;
    logic [AW-1:0] dst;
    logic [3:0] count;
    logic rd_valid;
    logic rd_mem;
    logic [15:0] rd_q;
    logic scan_done;
  } unit_state_t;

  unit_state_t s;
  unit_state_t next_s;

  logic mem_a_we;
  logic [AW-1:0] mem_a_addr;
  logic [15:0] mem_a_rdata;
  logic mem_b_we;
  logic [AW-1:0] mem_b_addr;
  logic [15:0] mem_b_wdata;
  logic [15:0] mem_b_rdata;

  // Operand order in the fetch: source one low/high, source two low/high, destination low/high.
  function automatic logic [AW-1:0] fetch_addr(input logic [2:0] idx, input logic [AW-1:0] a1,
                                               input logic [AW-1:0] a2, input logic [AW-1:0] ad);
    case (idx)
      3'h0: fetch_addr = a1;
      3'h1: fetch_addr = a1 + AW'(1);
      3'h2: fetch_addr = a2;
      3'h3: fetch_addr = a2 + AW'(1);
      3'h4: fetch_addr = ad;
      3'h5: fetch_addr = ad + AW'(1);
      default: fetch_addr = ad;
    endcase
  endfunction

  // Sign extension to a width that holds any true sum of two wide operands.
  function automatic logic signed [32:0] ext33(input logic [15:0] lo, input logic [15:0] hi,
                                               input logic wide);
    if (wide) begin
      ext33 = $signed({hi[15], hi, lo}); // [RQ3]
    end else begin
      ext33 = $signed({{17{lo[15]}}, lo}); // [RQ3]
    end
  endfunction

  function automatic logic [15:0] rotate(input logic [15:0] d, input logic [3:0] k,
                                         input logic left);
    logic [31:0] dd;
    dd = {d, d};
    if (left) begin
      dd = dd << k;
      rotate = dd[31:16];
    end else begin
      dd = dd >> k;
      rotate = dd[15:0];
    end
  endfunction

  function automatic logic [7:0] steps_of(input op_t op, input logic wide);
    case (op)
      SUM_OP: steps_of = wide ? `STEPS_WIDE : `STEPS_ADD;
      DIFFERENCE_OP: steps_of = wide ? `STEPS_WIDE : `STEPS_SUB; // [RQ7]
      PRODUCT_OP: steps_of = `STEPS_MUL;
      QUOTIENT_OP: steps_of = `STEPS_DIV;
      PLUS_ONE_OP: steps_of = `STEPS_STEP;
      MINUS_ONE_OP: steps_of = `STEPS_STEP;
      default: steps_of = `STEPS_ROT;
    endcase
  endfunction

  plc_word_store #(
    .WIDTH(16),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_store (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .a_we(mem_a_we),
    .a_addr(mem_a_addr),
    .a_wdata(reg_wdata),
    .a_rdata(mem_a_rdata),
    .b_we(mem_b_we),
    .b_addr(mem_b_addr),
    .b_wdata(mem_b_wdata),
    .b_rdata(mem_b_rdata)
  );

  always_comb begin
    logic is_data;
    logic fire;
    logic signed [32:0] a33;
    logic signed [32:0] b33;
    logic signed [32:0] d33;
    logic signed [32:0] r33;
    logic signed [32:0] lim_max;
    logic signed [32:0] lim_min;
    logic signed [31:0] prod;
    logic signed [15:0] quo;
    logic signed [15:0] rem;
    logic [15:0] rot;
    is_data = (reg_addr & ~8'(DEPTH - 1)) == `DATA_BASE;
    fire = 1'b0;
    a33 = ext33(s.opnd[0], s.opnd[1], s.wide);
    b33 = ext33(s.opnd[2], s.opnd[3], s.wide);
    d33 = ext33(s.opnd[4], s.opnd[5], s.wide);
    r33 = '0;
    lim_max = s.wide ? `S32_MAX : `S16_MAX;
    lim_min = s.wide ? `S32_MIN : `S16_MIN;
    prod = $signed(s.opnd[0]) * $signed(s.opnd[2]); // [RQ9]
    quo = '0;
    rem = '0;
    rot = rotate(s.opnd[4], s.count, s.op == SPIN_LEFT_OP);
    next_s = s;
    next_s.scan_done = 1'b0;
    next_s.run_meta = run_contact;
    next_s.run_sync = s.run_meta;
    mem_a_we = 1'b0;
    mem_a_addr = reg_addr[AW-1:0];
    mem_b_we = 1'b0;
    mem_b_addr = fetch_addr(s.cnt, s.src1, s.src2, s.dst);
    mem_b_wdata = '0;

    // Software side; configuration writes are ignored while an operation runs.
    next_s.rd_valid = reg_rd;
    next_s.rd_mem = reg_rd & is_data;
    next_s.rd_q = '0;
    if (reg_wr) begin
      if (is_data) begin
        mem_a_we = 1'b1;
      end else begin
        case (reg_addr)
          `REG_CTRL: begin
            if (s.st == ST_IDLE) begin
              next_s.op = op_t'(reg_wdata[`CTRL_OP_LSB +: 3]);
              next_s.pulse_form = reg_wdata[`CTRL_FORM_BIT];
              next_s.wide = reg_wdata[`CTRL_WIDE_BIT];
            end
          end
          `REG_SRC1: if (s.st == ST_IDLE) next_s.src1 = reg_wdata[AW-1:0];
          `REG_SRC2: if (s.st == ST_IDLE) next_s.src2 = reg_wdata[AW-1:0];
          `REG_DST: if (s.st == ST_IDLE) next_s.dst = reg_wdata[AW-1:0];
          `REG_COUNT: if (s.st == ST_IDLE) next_s.count = reg_wdata[3:0];
          `REG_FLAGS: begin
            next_s.zero_flag = s.zero_flag & ~reg_wdata[`FLAG_ZERO_BIT];
            next_s.borrow_flag = s.borrow_flag & ~reg_wdata[`FLAG_BORROW_BIT];
            next_s.carry_flag = s.carry_flag & ~reg_wdata[`FLAG_CARRY_BIT];
          end
          `REG_STATUS: next_s.div_zero = s.div_zero & ~reg_wdata[`STATUS_DIVZ_BIT];
          default: ;
        endcase
      end
    end
    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: next_s.rd_q = 16'({s.wide, s.pulse_form, s.op});
        `REG_SRC1: next_s.rd_q = 16'(s.src1);
        `REG_SRC2: next_s.rd_q = 16'(s.src2);
        `REG_DST: next_s.rd_q = 16'(s.dst);
        `REG_COUNT: next_s.rd_q = 16'(s.count);
        `REG_FLAGS: next_s.rd_q = 16'({s.carry_flag, s.borrow_flag, s.zero_flag});
        `REG_STATUS: begin
          next_s.rd_q[`STATUS_BUSY_BIT] = s.st != ST_IDLE;
          next_s.rd_q[`STATUS_DIVZ_BIT] = s.div_zero;
          next_s.rd_q[`STATUS_STEPS_LSB +: 8] = steps_of(s.op, s.wide); // [RQ7]
        end
        default: next_s.rd_q = '0;
      endcase
    end

    // Engine side; its flag updates come last so they win over a software clear.
    case (s.st)
      ST_IDLE: begin
        if (scan_strobe) begin
          next_s.run_prev = s.run_sync;
          fire = s.pulse_form ? (s.run_sync & ~s.run_prev) : s.run_sync; // [RQ12] [RQ14]
          if (fire) begin // [RQ11] [RQ18]
            next_s.st = ST_FETCH;
            next_s.cnt = '0;
          end else begin
            next_s.scan_done = 1'b1; // [RQ19]
          end
        end
      end
      ST_FETCH: begin
        if (s.cnt != 3'h0) begin
          next_s.opnd[s.cnt - 3'h1] = mem_b_rdata;
        end
        if (s.cnt == `FETCH_LAST) begin
          next_s.st = ST_EXEC;
        end else begin
          next_s.cnt = s.cnt + 3'h1;
        end
      end
      ST_EXEC: begin
        mem_b_addr = s.dst;
        next_s.st = ST_IDLE;
        next_s.scan_done = 1'b1;
        case (s.op)
          SUM_OP, DIFFERENCE_OP: begin
            r33 = (s.op == SUM_OP) ? a33 + b33 : a33 - b33; // [RQ1] [RQ2]
            mem_b_we = 1'b1;
            mem_b_wdata = r33[15:0];
            next_s.res_hi = r33[31:16];
            next_s.zero_flag = r33 == '0; // [RQ4]
            next_s.borrow_flag = r33 < lim_min; // [RQ5]
            next_s.carry_flag = r33 > lim_max; // [RQ6]
          end
          PLUS_ONE_OP, MINUS_ONE_OP: begin
            // The high bits of r33 are dropped, so the maximum steps to the minimum.
            r33 = (s.op == PLUS_ONE_OP) ? d33 + 33'sd1 : d33 - 33'sd1; // [RQ13] [RQ15]
            mem_b_we = 1'b1;
            mem_b_wdata = r33[15:0];
            next_s.res_hi = r33[31:16];
          end
          PRODUCT_OP: begin
            mem_b_we = 1'b1;
            mem_b_wdata = prod[15:0]; // [RQ8]
            next_s.res_hi = prod[31:16];
          end
          QUOTIENT_OP: begin
            if (s.opnd[2] == 16'h0000) begin
              next_s.div_zero = 1'b1; // [RQ20]
            end else begin
              quo = $signed(s.opnd[0]) / $signed(s.opnd[2]); // [RQ10]
              rem = $signed(s.opnd[0]) % $signed(s.opnd[2]);
              mem_b_we = 1'b1;
              mem_b_wdata = quo;
              next_s.res_hi = rem;
            end
          end
          default: begin
            mem_b_we = 1'b1;
            mem_b_wdata = rot; // [RQ16] [RQ18]
            if (s.count != 4'h0) begin
              next_s.carry_flag = (s.op == SPIN_LEFT_OP) ? rot[0] : rot[15]; // [RQ17]
            end
          end
        endcase
        if (mem_b_we && (s.op == PRODUCT_OP || s.op == QUOTIENT_OP || (s.wide &&
            (s.op == SUM_OP || s.op == DIFFERENCE_OP || s.op == PLUS_ONE_OP ||
             s.op == MINUS_ONE_OP)))) begin
          next_s.st = ST_WRITE_HI;
          next_s.scan_done = 1'b0;
        end
      end
      ST_WRITE_HI: begin
        mem_b_addr = s.dst + AW'(1);
        mem_b_we = 1'b1;
        mem_b_wdata = s.res_hi; // [RQ8] [RQ10]
        next_s.st = ST_IDLE;
        next_s.scan_done = 1'b1;
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= unit_state_t'(`STATE_RST);
    end else begin
      s <= next_s;
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  assign reg_rdata = !s.rd_valid ? 16'h0000 : (s.rd_mem ? mem_a_rdata : s.rd_q);
  assign busy = s.st != ST_IDLE;
  assign scan_done = s.scan_done;
  assign zero_flag = s.zero_flag;
  assign borrow_flag = s.borrow_flag;
  assign carry_flag = s.carry_flag;

endmodule // plc_integer_arithmetic_unit

/* plc_word_store.sv */
// Dual-port word store holding the data registers, with registered read data.
`timescale 1ns/1ps
module plc_word_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Software port
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [WIDTH-1:0] a_wdata,
  output logic [WIDTH-1:0] a_rdata,
  // Engine port
  input wire logic b_we,
  input wire logic [AW-1:0] b_addr,
  input wire logic [WIDTH-1:0] b_wdata,
  output logic [WIDTH-1:0] b_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Both writes share one process so that the engine wins a same-address collision.
  always_ff @(posedge clk_sys) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      a_rdata <= '0;
      b_rdata <= '0;
    end else begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end

endmodule // plc_word_store

/* test_plc_integer_arithmetic_unit.sv */
// Self-checking bench for the integer arithmetic unit.
`timescale 1ns/1ps
`include "plc_arith_map.svh"
module test_plc_integer_arithmetic_unit import plc_arith_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic scan_strobe = 1'b0;
  logic run_contact = 1'b0;
  logic [15:0] reg_rdata;
  logic busy, scan_done, zero_flag, borrow_flag, carry_flag;
  logic [15:0] rv;
  int lat;
  int errors = 0;
  int check_count = 0;

  plc_integer_arithmetic_unit #(.DEPTH(64), .AW(6)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scan_strobe(scan_strobe),
    .run_contact(run_contact), .busy(busy), .scan_done(scan_done), .zero_flag(zero_flag),
    .borrow_flag(borrow_flag), .carry_flag(carry_flag));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken at that negedge.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rv = reg_rdata;
  endtask

  task automatic chkw(input logic [7:0] i, input logic [15:0] e);
    rd(`DATA_BASE + i);
    chk("word", rv, e);
  endtask

  task automatic cfg(input op_t op, input logic p, input logic w, input logic [3:0] n);
    wr(`REG_CTRL, {11'h000, w, p, op});
    wr(`REG_COUNT, {12'h000, n});
  endtask

  // The contact is synchronised, so a scan must not start until it has settled.
  task automatic run(input logic on);
    @(posedge clk_sys);
    run_contact <= on;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic scan();
    int i;
    @(posedge clk_sys);
    scan_strobe <= 1'b1;
    @(posedge clk_sys);
    scan_strobe <= 1'b0;
    for (i = 0; i < 20; i++) begin
      @(negedge clk_sys);
      if (scan_done === 1'b1) break;
    end
    // Latency counts cycles after the strobe edge, so a scan that does not fire reads 1.
    lat = i + 1;
    if (i == 20) begin
      errors++;
      end_sim();
    end
  endtask

  task automatic arith(input logic [15:0] a, b, e, input logic [2:0] f);
    wr(`DATA_BASE, a);
    wr(`DATA_BASE + 8'h02, b);
    scan();
    chkw(8'h04, e);
    rd(`REG_FLAGS);
    chk("flags", rv, {13'h0000, f});
  endtask

  task automatic t_add();
    cfg(SUM_OP, 1'b0, 1'b0, 4'h0);
    arith(16'h7fff, 16'h0001, 16'h8000, 3'b100);
    arith(16'h8000, 16'hffff, 16'h7fff, 3'b010);
    arith(16'h0005, 16'hfffb, 16'h0000, 3'b001);
  endtask

  task automatic t_sub();
    cfg(DIFFERENCE_OP, 1'b0, 1'b0, 4'h0);
    arith(16'h8000, 16'h0001, 16'h7fff, 3'b010);
    arith(16'h7fff, 16'hffff, 16'h8000, 3'b100);
    arith(16'h1234, 16'h1234, 16'h0000, 3'b001);
    rd(`REG_STATUS);
    chk("steps", {8'h00, rv[15:8]}, 16'h0007);
    cfg(DIFFERENCE_OP, 1'b0, 1'b1, 4'h0);
    rd(`REG_STATUS);
    chk("steps", {8'h00, rv[15:8]}, 16'h000d);
    wr(`DATA_BASE + 8'h01, 16'h0001);
    wr(`DATA_BASE + 8'h03, 16'h0000);
    arith(16'h0000, 16'h0001, 16'hffff, 3'b000);
    chkw(8'h05, 16'h0000);
  endtask

  task automatic t_mul();
    cfg(PRODUCT_OP, 1'b0, 1'b0, 4'h0);
    wr(`DATA_BASE, 16'hfffd);
    wr(`DATA_BASE + 8'h02, 16'h0007);
    scan();
    chk("latency", 16'(lat), 16'h000a);
    chkw(8'h04, 16'hffeb);
    chkw(8'h05, 16'hffff);
    wr(`DATA_BASE, 16'h7fff);
    wr(`DATA_BASE + 8'h02, 16'h7fff);
    scan();
    chkw(8'h04, 16'h0001);
    chkw(8'h05, 16'h3fff);
  endtask

  task automatic t_div();
    cfg(QUOTIENT_OP, 1'b0, 1'b0, 4'h0);
    wr(`DATA_BASE, 16'hfff9);
    wr(`DATA_BASE + 8'h02, 16'h0002);
    scan();
    chkw(8'h04, 16'hfffd);
    chkw(8'h05, 16'hffff);
    wr(`DATA_BASE, 16'h0064);
    wr(`DATA_BASE + 8'h02, 16'h0000);
    scan();
    chkw(8'h04, 16'hfffd);
    chkw(8'h05, 16'hffff);
    rd(`REG_STATUS);
    chk("divz", {15'h0000, rv[`STATUS_DIVZ_BIT]}, 16'h0001);
  endtask

  task automatic t_step();
    cfg(PLUS_ONE_OP, 1'b0, 1'b0, 4'h0);
    wr(`DATA_BASE + 8'h04, 16'h7ffe);
    scan();
    scan();
    chkw(8'h04, 16'h8000);
    cfg(MINUS_ONE_OP, 1'b0, 1'b0, 4'h0);
    scan();
    chkw(8'h04, 16'h7fff);
    cfg(PLUS_ONE_OP, 1'b1, 1'b0, 4'h0);
    run(1'b0);
    scan();
    run(1'b1);
    scan();
    scan();
    chkw(8'h04, 16'h8000);
    cfg(MINUS_ONE_OP, 1'b1, 1'b0, 4'h0);
    run(1'b0);
    scan();
    run(1'b1);
    scan();
    scan();
    chkw(8'h04, 16'h7fff);
    cfg(PLUS_ONE_OP, 1'b0, 1'b1, 4'h0);
    wr(`DATA_BASE + 8'h04, 16'hffff);
    wr(`DATA_BASE + 8'h05, 16'h7fff);
    scan();
    chkw(8'h04, 16'h0000);
    chkw(8'h05, 16'h8000);
    cfg(MINUS_ONE_OP, 1'b0, 1'b1, 4'h0);
    scan();
    chkw(8'h04, 16'hffff);
    chkw(8'h05, 16'h7fff);
  endtask

  task automatic t_rot();
    cfg(SPIN_RIGHT_OP, 1'b0, 1'b0, 4'h4);
    wr(`REG_FLAGS, 16'h0007);
    wr(`DATA_BASE + 8'h04, 16'h123c);
    scan();
    chkw(8'h04, 16'hc123);
    rd(`REG_FLAGS);
    chk("flags", rv, 16'h0004);
    wr(`DATA_BASE + 8'h04, 16'h1234);
    scan();
    chkw(8'h04, 16'h4123);
    rd(`REG_FLAGS);
    chk("flags", rv, 16'h0000);
    cfg(SPIN_LEFT_OP, 1'b1, 1'b0, 4'h4);
    wr(`DATA_BASE + 8'h04, 16'h9123);
    run(1'b0);
    scan();
    run(1'b1);
    scan();
    scan();
    chkw(8'h04, 16'h1239);
    rd(`REG_FLAGS);
    chk("flags", rv, 16'h0004);
  endtask

  task automatic t_off();
    logic [15:0] f;
    cfg(SUM_OP, 1'b0, 1'b0, 4'h0);
    wr(`DATA_BASE + 8'h04, 16'h0055);
    run(1'b0);
    rd(`REG_FLAGS);
    f = rv;
    wr(8'h20, 16'hffff);
    scan();
    chk("latency", 16'(lat), 16'h0001);
    chkw(8'h04, 16'h0055);
    rd(`REG_FLAGS);
    chk("flags", rv, f);
    rd(8'h20);
    chk("unmapped", rv, 16'h0000);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(`REG_SRC2, 16'h0002);
    wr(`REG_DST, 16'h0004);
    run(1'b1);
    t_add();
    t_sub();
    t_mul();
    t_div();
    t_step();
    t_rot();
    t_off();
    end_sim();
  end
endmodule // test_plc_integer_arithmetic_unit
